/* rtl/flash_sig_pkg.sv */
// package for the flash access-time and checksum controller
// assumes one system clock and a wishbone register port
package flash_sig_pkg;

    // register byte offsets
    localparam logic [7:0] off_timing  = 8'h10;
    localparam logic [7:0] off_first   = 8'h20;
    localparam logic [7:0] off_last    = 8'h24;
    localparam logic [7:0] off_status  = 8'h28;
    localparam logic [7:0] off_result  = 8'h2c;
    localparam logic [7:0] off_mask    = 8'h30;

    // field positions
    localparam int tim_lo      = 0;
    localparam int tim_hi      = 1;
    localparam int idx_hi      = 16;
    localparam int go_bit      = 31;
    localparam int fin_bit     = 0;

    // reset values
    localparam logic [1:0]  tim_reset   = 2'h1;
    localparam logic [29:0] cfg_upper_reset = 30'h0;
    localparam logic [16:0] idx_reset   = 17'h0;

    // self-timed array read, ns, and derived cycles (least time: round up)
    localparam int clk_period_ps   = 5000;
    localparam int self_read_ns    = 20;
    localparam int self_read_cyc   =
        (self_read_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
    localparam logic [3:0] self_read_cnt = 4'(self_read_cyc);

    // flash array data: 32 corrected bits plus parity and check bits
    localparam int ecc_w = 6;

    typedef struct packed {
        logic [31:0] data;
        logic [ecc_w-1:0] ecc;
    } flash_word_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef enum logic [1:0] {
        sig_idle,
        sig_addr,
        sig_wait
    } sig_state_e;

endpackage

/* rtl/flash_misr.sv */
// 32-bit multiple-input signature register step
// assumes the caller holds enable for one cycle per flash word
`timescale 1ns/1ps
`default_nettype none
module flash_misr
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // control
    input  wire logic        clear,
    input  wire logic        enable,
    input  wire logic [31:0] word,
    // result
    output logic [31:0]      result_value
);
    typedef struct packed {
        logic [31:0] sign;
    } misr_s;

    misr_s st;
    misr_s next_st;

    always_comb
    begin
        next_st = st;
        if (clear)
        begin
            next_st.sign = 32'h0;
        end
        else if (enable)
        begin
            next_st.sign[30:0] = word[30:0] ^ st.sign[31:1];
            next_st.sign[31] = word[31] ^ st.sign[0] ^ st.sign[10]
                             ^ st.sign[30] ^ st.sign[31];
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            st <= '{sign: 32'h0};
        else
            st <= next_st;
    end

    assign result_value = st.sign;
endmodule
`default_nettype wire

/* rtl/flash_bus_wait.sv */
// wait-state inserter for processor reads of the flash array
// assumes a request held until ready; hold forces ready low
`timescale 1ns/1ps
`default_nettype none
module flash_bus_wait
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // control
    input  wire logic [1:0] access_cycles,
    input  wire logic       hold,
    // processor flash read
    input  wire logic       rd_req,
    output logic            rd_ready
);
    typedef struct packed {
        logic [1:0] cnt;
        logic       busy;
        logic       rdy;
    } wait_s;

    wait_s st;
    wait_s next_st;

    always_comb
    begin
        next_st = st;
        next_st.rdy = 1'b0;
        if (!rd_req || hold)
        begin
            // stalled while the checksum owns the array
            next_st.busy = 1'b0;
            next_st.cnt = 2'h0;
        end
        else if (st.rdy)
        begin
            next_st.busy = 1'b0;
        end
        else if (!st.busy)
        begin
            next_st.busy = 1'b1;
            next_st.cnt = access_cycles;
            next_st.rdy = (access_cycles == 2'h0);
            if (access_cycles == 2'h0)
                next_st.busy = 1'b0;
        end
        else if (st.cnt == 2'h1)
        begin
            next_st.rdy = 1'b1;
            next_st.busy = 1'b0;
        end
        else
        begin
            next_st.cnt = st.cnt - 2'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            st <= '{cnt: 2'h0, busy: 1'b0, rdy: 1'b0};
        else
            st <= next_st;
    end

    assign rd_ready = st.rdy;
endmodule
`default_nettype wire

/* rtl/flash_sig_ctrl.sv */
// flash access-time setting and embedded checksum generator
// assumes a flash array that answers a read after self_read_cnt cycles
`timescale 1ns/1ps
`default_nettype none
module flash_sig_ctrl
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // processor flash read wait control
    input  wire logic        cpu_flash_rd,
    output logic             cpu_flash_ready,
    // array read port for the checksum walk
    output logic             sig_rd,
    output logic [16:0]      sig_word_addr,
    input  wire logic [31:0] sig_rd_data,
    input  wire logic [5:0]  sig_rd_ecc,
    // configuration and interrupt
    output logic [1:0]       access_cycles,
    output logic             irq
);
    typedef struct packed {
        logic [29:0]                   cfg_upper;
        logic [1:0]                    tim;
        logic [16:0]                   first;
        logic [16:0]                   last;
        logic                          go;
        logic                          fin;
        logic                          mask;
        logic [16:0]                   addr;
        logic [3:0]                    wcnt;
        flash_sig_pkg::sig_state_e     fsm;
        logic                          ack;
        logic [31:0]                   rdat;
        logic                          irq;
        logic                          sig_rd;
        logic                          misr_clr;
        logic                          misr_en;
        logic [31:0]                   fold;
    } ctrl_s;

    ctrl_s st;
    ctrl_s next_st;
    flash_sig_pkg::wb_req_s req;
    flash_sig_pkg::flash_word_s fw;
    logic [31:0] result_value;
    logic        stall_ready;

    function automatic logic [31:0] merge
    (
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                   adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
    assign fw = '{data: sig_rd_data, ecc: sig_rd_ecc};

    always_comb
    begin
        logic [31:0] w;
        logic        take;
        logic        fin_set;
        w = 32'h0;
        take = req.cyc && req.stb && !st.ack;
        fin_set = 1'b0;
        next_st = st;
        next_st.ack = take;
        next_st.misr_clr = 1'b0;
        next_st.misr_en = 1'b0;
        next_st.sig_rd = 1'b0;

        // checksum walk, needs no software once started
        unique case (st.fsm)
            flash_sig_pkg::sig_idle:
            begin
                if (st.go)
                begin
                    next_st.addr = st.first;
                    next_st.misr_clr = 1'b1;
                    next_st.fsm = flash_sig_pkg::sig_addr;
                end
            end
            flash_sig_pkg::sig_addr:
            begin
                next_st.sig_rd = 1'b1;
                next_st.wcnt = flash_sig_pkg::self_read_cnt;
                next_st.fsm = flash_sig_pkg::sig_wait;
            end
            flash_sig_pkg::sig_wait:
            begin
                if (st.wcnt > 4'h1)
                begin
                    next_st.wcnt = st.wcnt - 4'h1;
                end
                else
                begin
                    // parity and check bits folded into the low bits
                    next_st.fold = fw.data
                        ^ {26'h0, fw.ecc};
                    next_st.misr_en = 1'b1;
                    if (st.addr >= st.last)
                    begin
                        next_st.go = 1'b0;
                        fin_set = 1'b1;
                        next_st.fsm = flash_sig_pkg::sig_idle;
                    end
                    else
                    begin
                        next_st.addr = st.addr + 17'h1;
                        next_st.fsm = flash_sig_pkg::sig_addr;
                    end
                end
            end
        endcase

        if (take)
        begin
            unique case (req.adr)
                flash_sig_pkg::off_timing:
                    w = {st.cfg_upper, st.tim};
                flash_sig_pkg::off_first:
                    w = {15'h0, st.first};
                flash_sig_pkg::off_last:
                    w = {st.go, 14'h0, st.last};
                flash_sig_pkg::off_status:
                    w = {31'h0, st.fin};
                flash_sig_pkg::off_result:
                    w = result_value;
                flash_sig_pkg::off_mask:
                    w = {31'h0, st.mask};
                default:
                    w = 32'h0;
            endcase
            next_st.rdat = w;
            if (req.we)
            begin
                w = merge(w, req.dat, req.sel);
                unique case (req.adr)
                    flash_sig_pkg::off_timing:
                    begin
                        // upper bits kept as software writes them back
                        next_st.cfg_upper = w[31:2];
                        next_st.tim = w[flash_sig_pkg::tim_hi:
                                        flash_sig_pkg::tim_lo];
                    end
                    flash_sig_pkg::off_first:
                        // writes ignored while walking
                        if (!st.go)
                            next_st.first = w[flash_sig_pkg::idx_hi:0];
                    flash_sig_pkg::off_last:
                        if (!st.go)
                        begin
                            next_st.last = w[flash_sig_pkg::idx_hi:0];
                            next_st.go = w[flash_sig_pkg::go_bit];
                        end
                    flash_sig_pkg::off_status:
                        if (w[flash_sig_pkg::fin_bit])
                            next_st.fin = 1'b0;
                    flash_sig_pkg::off_mask:
                        next_st.mask = w[0];
                    default:
                    begin
                    end
                endcase
            end
        end

        // set wins over a same-cycle clear
        if (fin_set)
            next_st.fin = 1'b1;
        next_st.irq = next_st.fin && next_st.mask;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.tim <= flash_sig_pkg::tim_reset;
            st.cfg_upper <= flash_sig_pkg::cfg_upper_reset;
            st.first <= flash_sig_pkg::idx_reset;
            st.last <= flash_sig_pkg::idx_reset;
            st.fsm <= flash_sig_pkg::sig_idle;
        end
        else
        begin
            st <= next_st;
        end
    end

    flash_misr u_misr
    (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .clear        (st.misr_clr),
        .enable       (st.misr_en),
        .word         (st.fold),
        .result_value (result_value)
    );

    flash_bus_wait u_wait
    (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .access_cycles (st.tim),
        .hold          (st.go),
        .rd_req        (cpu_flash_rd),
        .rd_ready      (stall_ready)
    );

    assign wb_dat_o = st.rdat;
    assign wb_ack_o = st.ack;
    assign cpu_flash_ready = stall_ready;
    assign sig_rd = st.sig_rd;
    assign sig_word_addr = st.addr;
    assign access_cycles = st.tim;
    assign irq = st.irq;
endmodule
`default_nettype wire

/* sim/flash_sig_ctrl_asserts.sv */
// port assertions for the flash access and checksum controller
// assumes it is bound onto every flash_sig_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module flash_sig_ctrl_asserts
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    // flash side
    input wire logic        cpu_flash_rd,
    input wire logic        cpu_flash_ready,
    input wire logic        sig_rd,
    input wire logic [16:0] sig_word_addr,
    input wire logic [1:0]  access_cycles
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ack_one_cycle: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack not one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    a_ready_pulse: assert property (
        cpu_flash_ready |=> !cpu_flash_ready)
        else $error("flash ready longer than one cycle");
    a_ready_wait: assert property (
        cpu_flash_ready |-> $past(cpu_flash_rd)
        && (access_cycles == 2'h0 || $past(cpu_flash_rd, 2)))
        else $error("flash ready before access time");
    a_slow_no_early: assert property (
        $rose(cpu_flash_rd) && access_cycles == 2'h1 |=> !cpu_flash_ready)
        else $error("two-cycle setting answered in one");
    a_walk_spacing: assert property (
        sig_rd |=> !sig_rd [*4])
        else $error("walk reads closer than self-timed read");
    a_walk_hold: assert property (
        sig_rd |=> $stable(sig_word_addr) [*3])
        else $error("walk address moved during a read");
    a_walk_step: assert property (
        sig_rd ##5 sig_rd |-> sig_word_addr == $past(sig_word_addr, 5) + 17'h1)
        else $error("walk skipped or repeated a word");
    a_walk_stall: assert property (
        sig_rd |-> !cpu_flash_ready [*5])
        else $error("processor read served during walk");
endmodule
bind flash_sig_ctrl flash_sig_ctrl_asserts i_flash_sig_ctrl_asserts
(
    .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cpu_flash_rd,
    .cpu_flash_ready, .sig_rd, .sig_word_addr, .access_cycles
);
`default_nettype wire

/* sim/flash_array_model.sv */
// behavioural flash array answering the checksum walk
// assumes one read in flight; data only valid in its window
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // array read port
    input  wire logic        sig_rd,
    input  wire logic [16:0] sig_word_addr,
    output logic      [31:0] sig_rd_data,
    output logic      [5:0]  sig_rd_ecc
);
    logic [16:0] adr;
    logic [2:0]  left;
    logic [15:0] spin;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            left <= 3'h0;
            adr  <= 17'h0;
            spin <= 16'h0;
        end
        else
        begin
            spin <= spin + 16'h1;
            if (sig_rd)
            begin
                left <= 3'h5;
                adr  <= sig_word_addr;
            end
            else if (left != 3'h0)
                left <= left - 3'h1;
        end
    end
    // lines wander outside the window so stale sampling shows up
    always_comb
    begin
        if (left != 3'h0)
        begin
            sig_rd_data = {15'h0, adr} * 32'h9e3779b9;
            sig_rd_ecc  = adr[5:0] ^ 6'h2a;
        end
        else
        begin
            sig_rd_data = {~spin, spin};
            sig_rd_ecc  = spin[5:0];
        end
    end
endmodule
`default_nettype wire

/* sim/flash_sig_ctrl_tb.sv */
// self-checking bench for the flash access and checksum controller
// assumes the array model answers the walk; one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module flash_sig_ctrl_tb;
    logic        sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        cpu_flash_rd, cpu_flash_ready, sig_rd, irq;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, sig_rd_data, rd, seed;
    logic [16:0] sig_word_addr;
    logic [5:0]  sig_rd_ecc;
    logic [1:0]  access_cycles;
    int          errors, checks_done, cyc_n;

    flash_sig_ctrl i_flash_sig_ctrl (.sys_clk, .rst, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .cpu_flash_rd, .cpu_flash_ready, .sig_rd,
        .sig_word_addr, .sig_rd_data, .sig_rd_ecc, .access_cycles, .irq);
    flash_array_model i_flash_array_model (.sys_clk, .rst, .sig_rd,
        .sig_word_addr, .sig_rd_data, .sig_rd_ecc);

    initial
    begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc_n <= cyc_n + 1;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [31:0] sig_of(input logic [31:0] f, l);
        logic [31:0] s, w;
        s = 32'h0;
        for (logic [31:0] a = f; a <= l; a++)
        begin
            w = a * 32'h9e3779b9 ^ {26'h0, a[5:0] ^ 6'h2a};
            s = {w[31] ^ s[0] ^ s[10] ^ s[30] ^ s[31], w[30:0] ^ s[31:1]};
        end
        return s;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
            @(posedge sys_clk);
        while (wb_ack_o !== 1'h1 && ++n < 50);
        if (wb_ack_o !== 1'h1)
            errors++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic cpu(output int lat);
        lat = 0;
        cpu_flash_rd <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            lat++;
        end
        while (cpu_flash_ready !== 1'h1 && lat < 3000);
        if (cpu_flash_ready !== 1'h1)
            errors++;
        cpu_flash_rd <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #100us;
        errors++;
        close_out();
    end

    initial
    begin
        int lat, n, t0;
        logic [31:0] f;
        {wb_cyc_i, wb_stb_i, wb_we_i, cpu_flash_rd} = 4'h0;
        {wb_adr_i, wb_dat_i, errors, checks_done, cyc_n} = '0;
        wb_sel_i = 4'hf;
        rst = 1'h1;
        seed = 32'hdf2a8b81;
        repeat (4) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        chk("cycles pin", 32'h1, {30'h0, access_cycles});
        bus(1'h0, 8'h10, 32'h0);
        chk("timing", 32'h1, {30'h0, rd[1:0]});
        bus(1'h0, 8'h20, 32'h0);
        chk("first", 32'h0, rd);
        bus(1'h0, 8'h24, 32'h0);
        chk("last", 32'h0, rd);
        bus(1'h0, 8'h3c, 32'h0);
        chk("unmapped", 32'h0, rd);
        for (int c = 0; c < 2; c++)
        begin
            bus(1'h0, 8'h10, 32'h0);
            bus(1'h1, 8'h10, {rd[31:2], 2'(c)});
            cpu(lat);
            chk("access", 32'(c + 2), 32'(lat));
        end
        for (int r = 0; r < 4; r++)
        begin
            seed = xs(seed);
            n = (r == 0) ? 1 : int'(seed[18:16]) + 1;
            f = {16'h0, seed[15:0]};
            bus(1'h1, 8'h30, 32'(r % 2 == 0));
            bus(1'h1, 8'h20, f);
            t0 = cyc_n;
            bus(1'h1, 8'h24, 32'h80000000 | (f + n - 1));
            fork
                cpu(lat);
                begin
                    bus(1'h0, 8'h24, 32'h0);
                    chk("busy", 32'h1, {31'h0, rd[31]});
                    do
                        bus(1'h0, 8'h28, 32'h0);
                    while (rd[0] !== 1'h1 && cyc_n - t0 < 2000);
                    // allow for the poll read in flight
                    chk("time", 32'h1, 32'(cyc_n - t0 <= 15 * n + 6));
                end
            join
            chk("stall", 32'h1, 32'(lat > 5 * n));
            chk("irq", 32'(r % 2 == 0), {31'h0, irq});
            bus(1'h0, 8'h24, 32'h0);
            chk("go clear", 32'h0, {31'h0, rd[31]});
            bus(1'h0, 8'h2c, 32'h0);
            chk("result", sig_of(f, f + n - 1), rd);
            bus(1'h1, 8'h28, 32'h1);
            chk("irq clear", 32'h0, {31'h0, irq});
        end
        close_out();
    end
endmodule
`default_nettype wire
